/* verification/link_sync_irq_status_checks_properties.sv */
/*
 * port assertions for the status/check block.
 * assumes a bind to the block's top module and one core clock.
 */
`timescale 1ns/1ps

module link_sync_irq_status_checks_properties
   import link_sync_irq_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic irq_n_o,
   // conditions
   input wire logic ch0_phase_outside_window_i,
   input wire logic ch0_align_tripped_i,
   input wire logic ch1_power_threshold_error_i,
   input wire logic ch1_align_locked_i,
   input wire logic [3:0] interp_factor_i,
   // latch enables
   input wire logic latch_en_ch0_window_i,
   input wire logic latch_en_ch0_trip_i,
   input wire logic latch_en_ch1_power_i,
   input wire logic latch_en_ch1_blank_i,
   input wire logic latch_en_ch1_lock_i,
   input wire logic latch_en_ch1_rotate_i,
   input wire logic latch_en_ch1_window_i,
   input wire logic latch_en_ch1_trip_i
);

////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // decoded reads and the all-live condition
   wire rd25 = reg_rd_i && reg_addr_i == CHAN0_EVENT_STATUS_ADDR;
   wire rd26 = reg_rd_i && reg_addr_i == CHAN1_EVENT_STATUS_ADDR;
   wire none_en = ~|{latch_en_ch0_window_i, latch_en_ch0_trip_i,
      latch_en_ch1_power_i, latch_en_ch1_blank_i, latch_en_ch1_lock_i,
      latch_en_ch1_rotate_i, latch_en_ch1_window_i, latch_en_ch1_trip_i};
   wire lock_quiet = latch_en_ch1_lock_i && !ch1_align_locked_i;

   // lock flag steps: rise, clear, quiet gap, read back
   sequence lock_rise_s;
      $rose(ch1_align_locked_i) && latch_en_ch1_lock_i ##1
         latch_en_ch1_lock_i;
   endsequence
   sequence lock_clr_s;
      reg_wr_i && reg_addr_i == CHAN1_EVENT_STATUS_ADDR &&
         reg_wdata_i[CH1_LOCK_BIT] && lock_quiet ##1 lock_quiet;
   endsequence

////////////////////////////////////////////////////////////////////////
   live_view_a: assert property (
      rd26 && !latch_en_ch1_lock_i |=>
      reg_rdata_o[CH1_LOCK_BIT] == $past(ch1_align_locked_i))
      else $error("live lock bit wrong");
   latch_irq_a: assert property (lock_rise_s |=> !irq_n_o)
      else $error("latched rise did not pull irq");
   clear_flag_a: assert property (
      lock_clr_s ##1 rd26 && lock_quiet |=> !reg_rdata_o[CH1_LOCK_BIT])
      else $error("lock flag not cleared");
   ch0_window_a: assert property (
      rd25 && !latch_en_ch0_window_i |=>
      reg_rdata_o[CH0_WINDOW_BIT] == $past(ch0_phase_outside_window_i))
      else $error("ch0 window bit wrong");
   ch0_trip_a: assert property (
      rd25 && !latch_en_ch0_trip_i |=>
      reg_rdata_o[CH0_TRIP_BIT] == $past(ch0_align_tripped_i))
      else $error("ch0 trip bit wrong");
   power_view_a: assert property (
      rd26 && !latch_en_ch1_power_i |=>
      reg_rdata_o[CH1_POWER_BIT] == $past(ch1_power_threshold_error_i))
      else $error("power bit wrong");
   interp_check_a: assert property (
      reg_rd_i && reg_addr_i == LINK_CONFIG_CHECKS_ADDR &&
      $stable(interp_factor_i) |=> reg_rdata_o[BAD_INTERP_BIT] ==
      !($past(interp_factor_i) inside {4'h1, 4'h2, 4'h4, 4'h8}))
      else $error("interp check bit wrong");
   irq_release_a: assert property (none_en [*2] |=> irq_n_o)
      else $error("irq held with no latch enable");
   reserved_zero_a: assert property (
      rd26 |=> !reg_rdata_o[6] && !reg_rdata_o[4])
      else $error("reserved bit set");

endmodule

bind link_sync_irq_status_checks link_sync_irq_status_checks_properties
   chk_u (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
   .reg_wdata_i, .reg_rdata_o, .irq_n_o, .ch0_phase_outside_window_i,
   .ch0_align_tripped_i, .ch1_power_threshold_error_i, .ch1_align_locked_i,
   .interp_factor_i, .latch_en_ch0_window_i, .latch_en_ch0_trip_i,
   .latch_en_ch1_power_i, .latch_en_ch1_blank_i, .latch_en_ch1_lock_i,
   .latch_en_ch1_rotate_i, .latch_en_ch1_window_i, .latch_en_ch1_trip_i);

/* verification/link_sync_irq_status_checks_tb.sv */
/*
 * self-checking bench for the status/check block.
 * assumes the package constants and a one-cycle read answer.
 */
`timescale 1ns/1ps

module link_sync_irq_status_checks_tb
   import link_sync_irq_pkg::*;
;
   logic clk, rst_n, wr, rd, combo, rvalid, irq_n;
   logic [11:0] addr;
   logic [7:0] wd, cnd, en, dly, k, rdata;
   logic [7:0] last;
   logic [1:0] c0, e0;
   logic [3:0] win, intp;
   logic [2:0] sub;
   int n_errors, num_checks;

   // short names for the three register offsets
   localparam logic [11:0] ST0 = CHAN0_EVENT_STATUS_ADDR;
   localparam logic [11:0] ST1 = CHAN1_EVENT_STATUS_ADDR;
   localparam logic [11:0] CHK = LINK_CONFIG_CHECKS_ADDR;

   // cnd and en follow the chan1 bit layout; 6 and 4 stay unused
   link_sync_irq_status_checks dut_u (
      .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .ch0_phase_outside_window_i(c0[1]),
      .ch0_align_tripped_i(c0[0]), .ch1_power_threshold_error_i(cnd[7]),
      .ch1_blanking_done_i(cnd[5]), .ch1_align_locked_i(cnd[3]),
      .ch1_align_rotated_i(cnd[2]), .ch1_phase_outside_window_i(cnd[1]),
      .ch1_align_tripped_i(cnd[0]), .latch_en_ch0_window_i(e0[1]),
      .latch_en_ch0_trip_i(e0[0]), .latch_en_ch1_power_i(en[7]),
      .latch_en_ch1_blank_i(en[5]), .latch_en_ch1_lock_i(en[3]),
      .latch_en_ch1_rotate_i(en[2]), .latch_en_ch1_window_i(en[1]),
      .latch_en_ch1_trip_i(en[0]), .frame_clock_delay_i(dly),
      .frames_per_multiframe_i(k), .window_limit_i(win),
      .link_combo_supported_i(combo), .subclass_i(sub),
      .interp_factor_i(intp), .irq_n_o(irq_n));

////////////////////////////////////////////////////////////////////////
   // expected check register image
   function automatic logic [7:0] chk_exp(logic [7:0] d, kk);
      chk_exp = {2'b00, d > kk, win > WINDOW_LIMIT_MAX, !combo,
         !(kk inside {8'h10, 8'h20}), sub > 3'h1,
         !(intp inside {4'h1, 4'h2, 4'h4, 4'h8})};
   endfunction

   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // single-bit results, checked against the bit position of the rule
   task automatic bit_chk(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // a missing rvalid turns into a forced mismatch
   task automatic rd_chk(logic [11:0] a, logic [7:0] exp, string what);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      last = rdata;
      cmp(what, exp, (rvalid === 1'b1) ? rdata : ~exp);
   endtask

   task automatic wr_do(logic [11:0] a, logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(40 * 4000);
      n_errors++;
      complete_run();
   end

   // main sequence
   initial begin
      void'($urandom(32'h7bf1));
      {rst_n, wr, rd, addr, wd, cnd, en, c0, e0} = '0;
      {dly, k, win, combo, sub, intp} = {8'h00, 8'h10, 4'h0, 1'b1, 7'h01};
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rd_chk(ST0, 8'h00, "chan0 reset");
      rd_chk(ST1, 8'h00, "chan1 reset");
      rd_chk(CHK, 8'h00, "checks reset");
      wr_do(ST1, 8'hff);
      for (int j = 0; j < 24; j++) begin
         cnd = 8'($urandom);
         c0 = 2'($urandom);
         rd_chk(ST1, cnd & 8'haf, "chan1 live");
         bit_chk("power", cnd[7], last[7]);
         bit_chk("blank", cnd[5], last[5]);
         bit_chk("lock", cnd[3], last[3]);
         bit_chk("rotate", cnd[2], last[2]);
         bit_chk("window1", cnd[1], last[1]);
         bit_chk("trip1", cnd[0], last[0]);
         rd_chk(ST0, {6'h0, c0}, "chan0 live");
         bit_chk("window0", c0[1], last[1]);
         bit_chk("trip0", c0[0], last[0]);
      end
      // latch mode: single-cycle pulses must be held
      cnd = 8'h00;
      c0 = 2'h0;
      en = 8'hff;
      e0 = 2'h3;
      @(negedge clk);
      cnd = 8'haf;
      c0 = 2'h3;
      @(negedge clk);
      cnd = 8'h00;
      c0 = 2'h0;
      repeat (2) @(negedge clk);
      cmp("irq set", 8'h00, {7'h0, irq_n});
      rd_chk(ST1, 8'haf, "chan1 held");
      rd_chk(ST0, 8'h03, "chan0 held");
      wr_do(ST1, 8'h48);
      rd_chk(ST1, 8'ha7, "chan1 clear");
      cmp("irq kept", 8'h00, {7'h0, irq_n});
      wr_do(ST1, 8'ha7);
      wr_do(ST0, 8'h03);
      repeat (2) @(negedge clk);
      cmp("irq free", 8'h01, {7'h0, irq_n});
      rd_chk(ST1, 8'h00, "chan1 empty");
      rd_chk(ST0, 8'h00, "chan0 empty");
      // a rise in the clear cycle must win; a dropped enable frees irq
      @(negedge clk);
      wr = 1'b1;
      addr = ST1;
      wd = 8'h01;
      cnd = 8'h01;
      @(negedge clk);
      wr = 1'b0;
      cnd = 8'h00;
      rd_chk(ST1, 8'h01, "set wins");
      en = 8'h00;
      e0 = 2'h0;
      repeat (2) @(negedge clk);
      cmp("irq dropped", 8'h01, {7'h0, irq_n});
      // check register: random settings plus K-equal delay corners
      for (int j = 0; j < 30; j++) begin
         k = (j % 3 == 0) ? 8'($urandom) : ((j % 3 == 1) ? 8'h10 : 8'h20);
         dly = j[0] ? k : 8'($urandom);
         {win, combo, sub, intp} = 12'($urandom);
         rd_chk(CHK, chk_exp(dly, k), "checks");
         bit_chk("combo", !combo, last[3]);
         bit_chk("k", !(k inside {8'h10, 8'h20}), last[2]);
         bit_chk("subclass", sub > 3'h1, last[1]);
      end
      {dly, k, win, combo, sub, intp} = {8'h20, 8'h20, 4'h3, 1'b1, 7'h18};
      wr_do(CHK, 8'hff);
      rd_chk(CHK, 8'h00, "checks edge");
      rd_chk(12'h0ff, 8'h00, "unmapped");
      complete_run();
   end

endmodule

/* verilog/event_flag_cell.sv */
/*
 * one status flag: live view or rising-edge latch with write-one clear.
 * assumes the condition comes from logic on the same core clock.
 */
`timescale 1ns/1ps

module event_flag_cell
   import link_sync_irq_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // condition and control
   input wire logic cond_i,
   input wire logic latch_en_i,
   input wire logic clear_i,
   // results
   output logic view_o,
   output logic pending_o
);

   logic cond_d_r;
   logic cond_d_nxt;
   logic flag_r;
   logic flag_nxt;
   logic rise;

   ////////////////////////////////////////////////////////////////////////
   // edge detect and latch; a set in the clear cycle wins so no event
   // is lost
   assign rise = cond_i & ~cond_d_r;

   always_comb begin
      cond_d_nxt = cond_i;
      flag_nxt = flag_r;
      if (!latch_en_i) begin
         flag_nxt = 1'b0; // live mode holds nothing
      end else if (rise) begin
         flag_nxt = 1'b1;
      end else if (clear_i) begin
         flag_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cond_d_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         cond_d_r <= cond_d_nxt;
         flag_r <= flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // what software sees and what pulls the interrupt
   assign view_o = latch_en_i ? flag_r : cond_i;
   assign pending_o = latch_en_i & flag_r;

endmodule

/* verilog/link_sync_irq_pkg.sv */
/*
 * constants shared by the status/check block and its flag cell:
 * register offsets, bit positions, reset values and check limits.
 * assumes an 8-bit register port with 12-bit byte offsets.
 */
package link_sync_irq_pkg;

   // register offsets on the register port
   localparam logic [11:0] CHAN0_EVENT_STATUS_ADDR = 12'h025;
   localparam logic [11:0] CHAN1_EVENT_STATUS_ADDR = 12'h026;
   localparam logic [11:0] LINK_CONFIG_CHECKS_ADDR = 12'h030;

   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CHECKS_RESET = 8'h00;

   // chan0_event_status bit positions
   localparam int CH0_TRIP_BIT = 0;
   localparam int CH0_WINDOW_BIT = 1;

   // chan1_event_status bit positions
   localparam int CH1_TRIP_BIT = 0;
   localparam int CH1_WINDOW_BIT = 1;
   localparam int CH1_ROTATE_BIT = 2;
   localparam int CH1_LOCK_BIT = 3;
   localparam int CH1_BLANK_BIT = 5;
   localparam int CH1_POWER_BIT = 7;

   // link_config_checks bit positions
   localparam int BAD_INTERP_BIT = 0;
   localparam int BAD_SUBCLASS_BIT = 1;
   localparam int BAD_K_BIT = 2;
   localparam int BAD_COMBO_BIT = 3;
   localparam int BAD_WINDOW_BIT = 4;
   localparam int DELAY_OVER_BIT = 5;

   // index of each flag in the internal flag vector
   localparam int FLAG_COUNT = 8;
   localparam int F_CH0_TRIP = 0;
   localparam int F_CH0_WINDOW = 1;
   localparam int F_CH1_TRIP = 2;
   localparam int F_CH1_WINDOW = 3;
   localparam int F_CH1_ROTATE = 4;
   localparam int F_CH1_LOCK = 5;
   localparam int F_CH1_BLANK = 6;
   localparam int F_CH1_POWER = 7;

   // supported link parameters
   localparam logic [7:0] K_SUPPORTED_A = 8'h10;
   localparam logic [7:0] K_SUPPORTED_B = 8'h20;
   localparam logic [2:0] SUBCLASS_MAX = 3'h1;
   localparam logic [3:0] WINDOW_LIMIT_MAX = 4'h3; // plain default

endpackage

/* verilog/link_sync_irq_status_checks.sv */
/*
 * interrupt status and link configuration checks for a two-channel
 * converter: two write-one-clear status registers, one read-only check
 * register and an active-low interrupt output.
 * assumes conditions and configuration come from core-clock logic and
 * that the register port gives one-cycle read and write strobes.
 */
// Behaviour
// - latch enable low: a read returns the condition's live state
// - latch enable high: flag sets on rising edge, holds, pulls irq low
// - writing one to a latched flag bit clears that flag unless a rising edge arrives in the same cycle
// - chan0 status bit 1: channel 0 phase outside alignment window
// - chan0 status bit 0: channel 0 alignment logic tripped
// - chan1 status at 0x026 bit 7: channel 1 over power threshold
// - chan1 status bit 5: channel 1 blanking finished
// - chan1 status register holds channel 1 alignment locked flag
// - chan1 status bit 2: channel 1 alignment rotated clock phase
// - chan1 status bit 1: channel 1 phase outside alignment window
// - chan1 status bit 0: channel 1 alignment logic tripped
// - check register 0x030 bit 5: frame delay above frames per multiframe
// - check bit 4: unsupported reference window limit
// - check bit 3: unsupported converter/lane/sample/octet combination
// - check bit 2: frames per multiframe other than 16 or 32
// - check bit 1: subclass neither 0 nor 1
// - check bit 0: interpolation not 1, 2, 4 or 8
`timescale 1ns/1ps

module link_sync_irq_status_checks
   import link_sync_irq_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // channel 0 conditions
   input wire logic ch0_phase_outside_window_i,
   input wire logic ch0_align_tripped_i,
   // channel 1 conditions
   input wire logic ch1_power_threshold_error_i,
   input wire logic ch1_blanking_done_i,
   input wire logic ch1_align_locked_i,
   input wire logic ch1_align_rotated_i,
   input wire logic ch1_phase_outside_window_i,
   input wire logic ch1_align_tripped_i,
   // latch-mode enables
   input wire logic latch_en_ch0_window_i,
   input wire logic latch_en_ch0_trip_i,
   input wire logic latch_en_ch1_power_i,
   input wire logic latch_en_ch1_blank_i,
   input wire logic latch_en_ch1_lock_i,
   input wire logic latch_en_ch1_rotate_i,
   input wire logic latch_en_ch1_window_i,
   input wire logic latch_en_ch1_trip_i,
   // link configuration under check
   input wire logic [7:0] frame_clock_delay_i,
   input wire logic [7:0] frames_per_multiframe_i,
   input wire logic [3:0] window_limit_i,
   input wire logic link_combo_supported_i,
   input wire logic [2:0] subclass_i,
   input wire logic [3:0] interp_factor_i,
   // interrupt
   output logic irq_n_o
);

   logic [FLAG_COUNT-1:0] cond;
   logic [FLAG_COUNT-1:0] latch_en;
   logic [FLAG_COUNT-1:0] clear;
   logic [FLAG_COUNT-1:0] view;
   logic [FLAG_COUNT-1:0] pending;
   logic [7:0] ch0_status;
   logic [7:0] ch1_status;
   logic [7:0] checks_r;
   logic [7:0] checks_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic irq_n_r;
   logic irq_n_nxt;
   logic wr_ch0;
   logic wr_ch1;

   // address match, used for both write strobes and the read mux
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   // interpolation factors the datapath supports
   function automatic logic interp_ok(input logic [3:0] f);
      interp_ok = (f == 4'h1) || (f == 4'h2) || (f == 4'h4) || (f == 4'h8);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // gather conditions and enables into flag order
   always_comb begin
      cond = '0;
      cond[F_CH0_TRIP] = ch0_align_tripped_i;
      cond[F_CH0_WINDOW] = ch0_phase_outside_window_i;
      cond[F_CH1_TRIP] = ch1_align_tripped_i;
      cond[F_CH1_WINDOW] = ch1_phase_outside_window_i;
      cond[F_CH1_ROTATE] = ch1_align_rotated_i;
      cond[F_CH1_LOCK] = ch1_align_locked_i;
      cond[F_CH1_BLANK] = ch1_blanking_done_i;
      cond[F_CH1_POWER] = ch1_power_threshold_error_i;
      latch_en = '0;
      latch_en[F_CH0_TRIP] = latch_en_ch0_trip_i;
      latch_en[F_CH0_WINDOW] = latch_en_ch0_window_i;
      latch_en[F_CH1_TRIP] = latch_en_ch1_trip_i;
      latch_en[F_CH1_WINDOW] = latch_en_ch1_window_i;
      latch_en[F_CH1_ROTATE] = latch_en_ch1_rotate_i;
      latch_en[F_CH1_LOCK] = latch_en_ch1_lock_i;
      latch_en[F_CH1_BLANK] = latch_en_ch1_blank_i;
      latch_en[F_CH1_POWER] = latch_en_ch1_power_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // write-one-clear strobes; reserved bit lanes are simply not wired
   assign wr_ch0 = reg_wr_i & hit(reg_addr_i, CHAN0_EVENT_STATUS_ADDR);
   assign wr_ch1 = reg_wr_i & hit(reg_addr_i, CHAN1_EVENT_STATUS_ADDR);

   always_comb begin
      clear = '0;
      clear[F_CH0_TRIP] = wr_ch0 & reg_wdata_i[CH0_TRIP_BIT];
      clear[F_CH0_WINDOW] = wr_ch0 & reg_wdata_i[CH0_WINDOW_BIT];
      clear[F_CH1_TRIP] = wr_ch1 & reg_wdata_i[CH1_TRIP_BIT];
      clear[F_CH1_WINDOW] = wr_ch1 & reg_wdata_i[CH1_WINDOW_BIT];
      clear[F_CH1_ROTATE] = wr_ch1 & reg_wdata_i[CH1_ROTATE_BIT];
      clear[F_CH1_LOCK] = wr_ch1 & reg_wdata_i[CH1_LOCK_BIT];
      clear[F_CH1_BLANK] = wr_ch1 & reg_wdata_i[CH1_BLANK_BIT];
      clear[F_CH1_POWER] = wr_ch1 & reg_wdata_i[CH1_POWER_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // one flag cell per status bit
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_COUNT; gi = gi + 1) begin : g_flag
         event_flag_cell u_cell (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .cond_i(cond[gi]),
            .latch_en_i(latch_en[gi]),
            .clear_i(clear[gi]),
            .view_o(view[gi]),
            .pending_o(pending[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // status register images; unused positions read zero
   always_comb begin
      ch0_status = STATUS_RESET;
      ch0_status[CH0_WINDOW_BIT] = view[F_CH0_WINDOW];
      ch0_status[CH0_TRIP_BIT] = view[F_CH0_TRIP];
      ch1_status = STATUS_RESET;
      ch1_status[CH1_POWER_BIT] = view[F_CH1_POWER];
      ch1_status[CH1_BLANK_BIT] = view[F_CH1_BLANK];
      ch1_status[CH1_LOCK_BIT] = view[F_CH1_LOCK];
      ch1_status[CH1_ROTATE_BIT] = view[F_CH1_ROTATE];
      ch1_status[CH1_WINDOW_BIT] = view[F_CH1_WINDOW];
      ch1_status[CH1_TRIP_BIT] = view[F_CH1_TRIP];
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration checks, registered so reads never see a glitch while
   // software is mid-way through reprogramming the link
   always_comb begin
      checks_nxt = CHECKS_RESET;
      checks_nxt[DELAY_OVER_BIT] =
         frame_clock_delay_i > frames_per_multiframe_i;
      checks_nxt[BAD_WINDOW_BIT] =
         window_limit_i > WINDOW_LIMIT_MAX;
      checks_nxt[BAD_COMBO_BIT] = ~link_combo_supported_i;
      checks_nxt[BAD_K_BIT] =
         (frames_per_multiframe_i != K_SUPPORTED_A) &&
         (frames_per_multiframe_i != K_SUPPORTED_B);
      checks_nxt[BAD_SUBCLASS_BIT] = subclass_i > SUBCLASS_MAX;
      checks_nxt[BAD_INTERP_BIT] =
         ~interp_ok(interp_factor_i);
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, read valid and interrupt; unmapped reads return zero
   always_comb begin
      rvalid_nxt = reg_rd_i;
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         if (hit(reg_addr_i, CHAN0_EVENT_STATUS_ADDR)) begin
            rdata_nxt = ch0_status;
         end else if (hit(reg_addr_i, CHAN1_EVENT_STATUS_ADDR)) begin
            rdata_nxt = ch1_status;
         end else if (hit(reg_addr_i, LINK_CONFIG_CHECKS_ADDR)) begin
            rdata_nxt = checks_r; // read-only: writes here are ignored
         end else begin
            rdata_nxt = 8'h00;
         end
      end
      irq_n_nxt = ~(|pending);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         checks_r <= CHECKS_RESET;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         irq_n_r <= 1'b1;
      end else begin
         checks_r <= checks_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         irq_n_r <= irq_n_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
   assign irq_n_o = irq_n_r;

endmodule
